//--- hdl/ecg_defs.svh
// Purpose: constants of the engine clock-gate override bank
// Assumes: a 20-bit register port address and 32-bit data words
// Notes: definitions only, shared by the package and the bank
`ifndef ECG_DEFS_SVH
`define ECG_DEFS_SVH

`define ECG_ADDR_W 20
`define ECG_DATA_W 32
`define ECG_NUM_REGS 3

// register offsets on the register port
`define ECG_ENG0_OFS 20'h46020
`define ECG_ENG1_OFS 20'h46024
`define ECG_RAM0_OFS 20'h46028

// writable bits of each register; the rest are reserved
`define ECG_ENG0_MASK 32'hFFFFFFFF
`define ECG_ENG1_MASK 32'h07FFFFFF
`define ECG_RAM0_MASK 32'hFFFFFFFF

// contents after full device reset
`define ECG_ENG0_RST 32'h00000000
`define ECG_ENG1_RST 32'h00000000
`define ECG_RAM0_RST 32'h00000000

// field layout
`define ECG_ENG0_UNITS 32
`define ECG_ENG1_UNITS 27
`define ECG_RAM0_UNITS 30
`define ECG_COMP_A_BIT 22
`define ECG_COMP_B_BIT 21

`endif

//--- hdl/ecg_pkg.sv
// Purpose: types of the engine clock-gate override bank
// Assumes: ecg_defs.svh provides the widths
// Notes: nothing here holds state
`include "ecg_defs.svh"

package ecg_pkg;

  // which register an address selects
  typedef enum logic [1:0] {
    ECG_SEL_ENG0,
    ECG_SEL_ENG1,
    ECG_SEL_RAM0,
    ECG_SEL_NONE
  } ecg_sel_t;

  // one access on the register port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`ECG_ADDR_W-1:0] addr;
    logic [`ECG_DATA_W-1:0] wdata;
  } ecg_req_t;

endpackage : ecg_pkg

//--- hdl/ecg_gate_bank.sv
// Purpose: three gating-override registers that hold unit clocks running
// Assumes: one request at a time on REQ_I, synchronous to CLK_I
// Notes: contents survive the graphics reset; only RST_N_I clears them
`timescale 1ns/1ps
`include "ecg_defs.svh"

module ecg_gate_bank (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic GFX_RST_N_I,
  input wire ecg_pkg::ecg_req_t REQ_I,
  output logic [`ECG_DATA_W-1:0] RDATA_O,
  output logic RVALID_O,
  output logic [`ECG_ENG0_UNITS-1:0] ENG_GATE_OVR0_O,
  output logic [`ECG_ENG1_UNITS-1:0] ENG_GATE_OVR1_O,
  output logic [`ECG_RAM0_UNITS-1:0] RAM_GATE_OVR_O,
  output logic COMPANION_OVERRIDE_A_O,
  output logic COMPANION_OVERRIDE_B_O
);

  ////////////////////////////////////////////////////////////////////////////
  // decoding

  function automatic ecg_pkg::ecg_sel_t decode_sel(input logic [`ECG_ADDR_W-1:0] addr);
    if (addr == `ECG_ENG0_OFS)
    begin
      decode_sel = ecg_pkg::ECG_SEL_ENG0;
    end
    else if (addr == `ECG_ENG1_OFS)
    begin
      decode_sel = ecg_pkg::ECG_SEL_ENG1;
    end
    else if (addr == `ECG_RAM0_OFS)
    begin
      decode_sel = ecg_pkg::ECG_SEL_RAM0;
    end
    else
    begin
      decode_sel = ecg_pkg::ECG_SEL_NONE;
    end
  endfunction : decode_sel

  function automatic logic [`ECG_DATA_W-1:0] sel_mask(input ecg_pkg::ecg_sel_t sel);
    case (sel)
      ecg_pkg::ECG_SEL_ENG0: sel_mask = `ECG_ENG0_MASK;
      ecg_pkg::ECG_SEL_ENG1: sel_mask = `ECG_ENG1_MASK;
      ecg_pkg::ECG_SEL_RAM0: sel_mask = `ECG_RAM0_MASK;
      default: sel_mask = 32'h00000000;
    endcase
  endfunction : sel_mask

  function automatic logic [`ECG_DATA_W-1:0] sel_reset(input ecg_pkg::ecg_sel_t sel);
    case (sel)
      ecg_pkg::ECG_SEL_ENG0: sel_reset = `ECG_ENG0_RST;
      ecg_pkg::ECG_SEL_ENG1: sel_reset = `ECG_ENG1_RST;
      default: sel_reset = `ECG_RAM0_RST;
    endcase
  endfunction : sel_reset

  ecg_pkg::ecg_sel_t sel;
  logic acc_ok;
  logic [`ECG_DATA_W-1:0] regs_q [`ECG_NUM_REGS];
  logic [`ECG_DATA_W-1:0] regs_d [`ECG_NUM_REGS];

  // the port is held off while the graphics reset is low, so nothing moves
  assign sel = decode_sel(REQ_I.addr);
  assign acc_ok = GFX_RST_N_I;

  ////////////////////////////////////////////////////////////////////////////
  // storage

  for (genvar g = 0; g < `ECG_NUM_REGS; g++)
  begin : g_reg
    localparam ecg_pkg::ecg_sel_t MY_SEL = ecg_pkg::ecg_sel_t'(2'(g));

    always_comb
    begin
      regs_d[g] = regs_q[g];
      if (acc_ok && REQ_I.wr && sel == MY_SEL)
      begin
        regs_d[g] = REQ_I.wdata & sel_mask(MY_SEL);
      end
    end

    // only the device reset touches these; graphics reset is not wired here
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
      if (!RST_N_I)
      begin
        regs_q[g] <= sel_reset(MY_SEL);
      end
      else
      begin
        regs_q[g] <= regs_d[g];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  logic [`ECG_DATA_W-1:0] rdata_q;
  logic [`ECG_DATA_W-1:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  // unmapped addresses answer zero so software never sees stale data
  always_comb
  begin
    rdata_d = 32'h00000000;
    rvalid_d = 1'b0;
    if (acc_ok && REQ_I.rd)
    begin
      rvalid_d = 1'b1;
      if (sel != ecg_pkg::ECG_SEL_NONE)
      begin
        rdata_d = regs_q[sel] & sel_mask(sel);
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rdata_q <= 32'h00000000;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign RDATA_O = rdata_q;
  assign RVALID_O = rvalid_q;

  ////////////////////////////////////////////////////////////////////////////
  // override lines

  // no resync stage: a gate cell sees the new level one edge after the write
  assign ENG_GATE_OVR0_O = regs_q[0];
  assign ENG_GATE_OVR1_O = regs_q[1][`ECG_ENG1_UNITS-1:0];
  assign RAM_GATE_OVR_O = regs_q[2][`ECG_RAM0_UNITS-1:0];
  assign COMPANION_OVERRIDE_A_O = regs_q[1][`ECG_COMP_A_BIT];
  assign COMPANION_OVERRIDE_B_O = regs_q[1][`ECG_COMP_B_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  logic wr_eng0;
  logic wr_eng1;
  logic wr_ram0;
  assign wr_eng0 = acc_ok && REQ_I.wr && sel == ecg_pkg::ECG_SEL_ENG0;
  assign wr_eng1 = acc_ok && REQ_I.wr && sel == ecg_pkg::ECG_SEL_ENG1;
  assign wr_ram0 = acc_ok && REQ_I.wr && sel == ecg_pkg::ECG_SEL_RAM0;

  clear_gate_a: assert property (
    wr_eng0 |=> (ENG_GATE_OVR0_O & ~$past(REQ_I.wdata)) == 32'h00000000
  ) else $error("engine override 0 kept a bit that was written as zero");

  eng0_write_a: assert property (
    wr_eng0 |=> ENG_GATE_OVR0_O == $past(REQ_I.wdata)
  ) else $error("engine override 0 does not follow its write");

  eng1_write_a: assert property (
    wr_eng1 |=> (ENG_GATE_OVR1_O == $past(REQ_I.wdata[26:0]))
      && (regs_q[1][31:27] == 5'h00)
  ) else $error("engine override 1 field or reserved bits wrong");

  ram_write_a: assert property (
    wr_ram0 ##1 (acc_ok && REQ_I.rd && sel == ecg_pkg::ECG_SEL_RAM0 && !REQ_I.wr)
      |=> (RDATA_O == $past(REQ_I.wdata, 2)) && (RAM_GATE_OVR_O == RDATA_O[29:0])
  ) else $error("ram override or spare bits not kept");

  gfx_hold_a: assert property (
    !GFX_RST_N_I |=> (regs_q[0] == $past(regs_q[0])) && (regs_q[1] == $past(regs_q[1]))
      && (regs_q[2] == $past(regs_q[2]))
  ) else $error("register contents moved during graphics reset");

  companion_pair_a: assert property (
    wr_eng1 |=> (COMPANION_OVERRIDE_A_O == $past(REQ_I.wdata[22]))
      && (COMPANION_OVERRIDE_B_O == $past(REQ_I.wdata[21]))
      && (ENG_GATE_OVR1_O[22:21] == {COMPANION_OVERRIDE_A_O, COMPANION_OVERRIDE_B_O})
  ) else $error("companion override lines do not track their bits");

  read_back_a: assert property (
    (acc_ok && REQ_I.rd && sel == ecg_pkg::ECG_SEL_ENG1)
      |=> RVALID_O && RDATA_O == {5'h00, $past(ENG_GATE_OVR1_O)}
  ) else $error("read of engine register 1 returned wrong data");

  read_unmapped_a: assert property (
    (acc_ok && REQ_I.rd && sel == ecg_pkg::ECG_SEL_NONE)
      |=> RVALID_O && RDATA_O == 32'h00000000
  ) else $error("unmapped read did not return zero");

  idle_hold_a: assert property (
    !(wr_eng0 || wr_eng1 || wr_ram0)
      |=> $stable(ENG_GATE_OVR0_O) && $stable(ENG_GATE_OVR1_O) && $stable(RAM_GATE_OVR_O)
  ) else $error("override lines changed without a write");

endmodule : ecg_gate_bank

//--- verif/ecg_gate_bank_tb.sv
// Purpose: self-checking bench for the engine clock-gate override bank
// Assumes: fixed one-cycle read answer, overrides visible the cycle after a write
// Notes: index 3 of the model stands for an unmapped address
`timescale 1ns/1ps

module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic gfx_rst_n = 1'b1;
  ecg_pkg::ecg_req_t req = '0;
  logic [31:0] rdata;
  logic rvalid;
  logic [31:0] ovr0;
  logic [26:0] ovr1;
  logic [29:0] ram_ovr;
  logic comp_a;
  logic comp_b;
  int fail_count = 0;
  int samples_checked = 0;
  logic [31:0] mdl [4] = '{32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000};
  logic [31:0] msk [4] = '{32'hFFFFFFFF, 32'h07FFFFFF, 32'hFFFFFFFF, 32'h00000000};
  logic [19:0] ofs [4] = '{20'h46020, 20'h46024, 20'h46028, 20'h4602C};

  always #10 clk = ~clk;

  ecg_gate_bank ecg_gate_bank_inst (
    .CLK_I(clk),
    .RST_N_I(rst_n),
    .GFX_RST_N_I(gfx_rst_n),
    .REQ_I(req),
    .RDATA_O(rdata),
    .RVALID_O(rvalid),
    .ENG_GATE_OVR0_O(ovr0),
    .ENG_GATE_OVR1_O(ovr1),
    .RAM_GATE_OVR_O(ram_ovr),
    .COMPANION_OVERRIDE_A_O(comp_a),
    .COMPANION_OVERRIDE_B_O(comp_b)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task note(input logic [31:0] got, input logic [31:0] exp);
  begin
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask : note

  task chk_rd(input logic exp_valid, input logic [31:0] exp);
  begin
    note({31'h00000000, rvalid}, {31'h00000000, exp_valid});
    note(rdata, exp);
  end
  endtask : chk_rd

  // companions are compared as their own pair so a swap between them shows up
  task chk_ovr;
  begin
    note(ovr0, mdl[0]);
    note({5'h00, ovr1}, mdl[1] & 32'h07FFFFFF);
    note({2'h0, ram_ovr}, mdl[2] & 32'h3FFFFFFF);
    note({30'h00000000, comp_a, comp_b}, {30'h00000000, mdl[1][22], mdl[1][21]});
  end
  endtask : chk_ovr

  // read in the same cycle as a write must return the value from before it
  task acc(input logic w, input logic r, input int i, input logic [31:0] d);
    logic [31:0] old;
  begin
    old = mdl[i];
    @(posedge clk);
    req <= {w, r, ofs[i], d};
    @(posedge clk);
    req <= '0;
    if (w && gfx_rst_n)
      mdl[i] = (mdl[i] & ~msk[i]) | (d & msk[i]);
    #1;
    chk_rd(r && gfx_rst_n, (r && gfx_rst_n) ? old : 32'h00000000);
    chk_ovr();
  end
  endtask : acc

  // write then read the same register on the very next edge, with no idle cycle between
  task wr_rd(input int i, input logic [31:0] d);
  begin
    @(posedge clk);
    req <= {1'b1, 1'b0, ofs[i], d};
    @(posedge clk);
    req <= {1'b0, 1'b1, ofs[i], 32'h00000000};
    mdl[i] = (mdl[i] & ~msk[i]) | (d & msk[i]);
    #1;
    chk_ovr();
    @(posedge clk);
    req <= '0;
    #1;
    chk_rd(1'b1, mdl[i]);
    chk_ovr();
  end
  endtask : wr_rd

  task wrap_up;
  begin
    if (fail_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(90));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++)
      acc(1'b0, 1'b1, i, 32'h00000000);
    repeat (40)
      acc(1'($urandom_range(1)), 1'($urandom_range(1)), $urandom_range(3), $urandom());
    for (int i = 0; i < 4; i++)
      acc(1'b1, 1'b1, i, 32'hFFFFFFFF);
    for (int i = 0; i < 4; i++)
      acc(1'b0, 1'b1, i, 32'h00000000);
    acc(1'b1, 1'b0, 1, 32'h00600800);
    acc(1'b1, 1'b0, 1, 32'h00400800);
    acc(1'b1, 1'b1, 1, 32'h00200800);
    for (int i = 0; i < 4; i++)
      wr_rd(i, $urandom());
    acc(1'b1, 1'b0, 1, 32'h00600800);
    acc(1'b1, 1'b0, 0, 32'h00040002);
    // graphics reset blocks the port but must not touch stored contents
    @(posedge clk);
    gfx_rst_n <= 1'b0;
    acc(1'b1, 1'b1, 0, $urandom());
    acc(1'b1, 1'b0, 1, 32'hFFFFFFFF);
    @(posedge clk);
    gfx_rst_n <= 1'b1;
    for (int i = 0; i < 4; i++)
      acc(1'b0, 1'b1, i, 32'h00000000);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 4; i++)
      mdl[i] = 32'h00000000;
    #1;
    chk_ovr();
    @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++)
      acc(1'b0, 1'b1, i, 32'h00000000);
    wrap_up();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
endmodule : testbench
